// ---- hdl/pc_fetch_pipeline_stack.sv ----
// Program counter, fetch/execute pipeline and return stack control with APB access.
//
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "seq_params.svh"

module pc_fetch_pipeline_stack (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`PADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Program memory
    output logic [`PC_WIDTH-1:0] fetch_addr,
    input wire logic [`WORD_WIDTH-1:0] fetch_word,
    // Instruction decoder
    output seq_pkg::exec_t exec,
    input wire seq_pkg::decode_t decode,
    // Interrupt logic
    input wire logic irq_req,
    input wire logic [`PC_WIDTH-1:0] irq_vector,
    output logic irq_ack,
    output logic stack_full,
    // Phase indication, bit 0 is the fetch phase
    output logic [`PHASE_COUNT-1:0] phase
);
    import seq_pkg::*;

    function automatic reg_sel_t reg_decode(input logic [`PADDR_WIDTH-1:0] addr);
        case (addr)
            `OFS_PC_LOW: reg_decode = SEL_PCL;
            `OFS_STATUS: reg_decode = SEL_STATUS;
            `OFS_CONTROL: reg_decode = SEL_CONTROL;
            default: reg_decode = SEL_NONE;
        endcase
    endfunction : reg_decode

    logic [`PC_WIDTH-1:0] pc_reg;
    logic [`PC_WIDTH-1:0] pc_next;
    logic [`WORD_WIDTH-1:0] prefetch_reg;
    logic prefetch_valid_reg;
    logic pcl_pending_reg;
    logic [7:0] pcl_data_reg;
    logic run_reg;
    logic overflow_reg;
    logic [`PHASE_COUNT-1:0] phase_w;
    logic [`PC_WIDTH-1:0] stack_top;
    logic boundary;
    logic capture;
    logic do_jump;
    logic do_call;
    logic do_ret;
    logic do_skip;
    logic branch;
    logic do_pcl;
    logic do_irq;
    logic redirect;
    logic push;
    logic pop;
    logic apb_access;
    logic apb_write;
    reg_sel_t sel;

    phase_gen #(
        .PHASES(`PHASE_COUNT)
    ) u_phase (
        .pclk(pclk),
        .presetn(presetn),
        .phase(phase_w)
    );

    return_stack #(
        .DEPTH(`STACK_DEPTH),
        .WIDTH(`PC_WIDTH)
    ) u_stack (
        .pclk(pclk),
        .presetn(presetn),
        .push(push),
        .pop(pop),
        .push_data(fetch_addr),
        .top_data(stack_top),
        .full(stack_full)
    );

    assign phase = phase_w;
    // The edge closing the last phase opens the next fetch phase.
    assign boundary = phase_w[`PHASE_COUNT-1] & run_reg;
    assign capture = phase_w[0];

    // The decoder looks at the executing word during the execute phases.
    always_comb begin
        do_jump = exec.valid && (decode.op == OP_JUMP || decode.op == OP_CALL);
        do_call = exec.valid && decode.op == OP_CALL;
        do_ret = exec.valid && (decode.op == OP_RET || decode.op == OP_RETURN_FROM_IRQ_OP);
        do_skip = exec.valid && decode.op == OP_SKIP && decode.skip_taken;
        branch = do_jump | do_ret | do_skip;
        do_pcl = pcl_pending_reg && !branch;
        // A full stack only withholds the acknowledge; the request stays with its owner.
        do_irq = irq_req && !stack_full && !branch && !pcl_pending_reg
                 && prefetch_valid_reg;
        redirect = branch | do_pcl | do_irq;
        if (do_jump) begin
            pc_next = decode.target;
        end else if (do_ret) begin
            pc_next = stack_top;
        end else if (do_pcl) begin
            pc_next = {fetch_addr[`PC_WIDTH-1:8], pcl_data_reg};
        end else if (do_irq) begin
            pc_next = irq_vector;
        end else begin
            pc_next = pc_reg;
        end
    end

    // The pushed address is the word fetched this cycle, the one that would run next.
    assign push = boundary && (do_call || do_irq);
    assign pop = boundary && do_ret;

    // Program counter and fetch address.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // The vector is fetched in the first cycle, so the counter already points past it.
            pc_reg <= `RESET_VECTOR + 11'h001;
            fetch_addr <= `RESET_VECTOR;
        end else if (boundary) begin
            fetch_addr <= pc_next;
            pc_reg <= pc_next + 1'b1;
        end
    end

    // Prefetch register, filled at the end of the fetch phase.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prefetch_reg <= '0;
            prefetch_valid_reg <= 1'b0;
        end else if (capture && run_reg) begin
            prefetch_reg <= fetch_word;
            prefetch_valid_reg <= 1'b1;
        end else if (boundary) begin
            prefetch_valid_reg <= 1'b0;
        end
    end

    // Execute stage. A redirect turns the word fetched beside it into a dummy cycle,
    // which is what makes every branch cost a second instruction cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            exec <= '0;
        end else if (boundary) begin
            exec.valid <= prefetch_valid_reg && !redirect;
            exec.addr <= fetch_addr;
            exec.word <= prefetch_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ack <= 1'b0;
        end else begin
            irq_ack <= boundary && do_irq;
        end
    end

    // APB slave with one wait state on every access.
    assign apb_access = psel && penable && !pready;
    assign apb_write = apb_access && pwrite;
    assign sel = reg_decode(paddr);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= apb_access;
            pslverr <= apb_access && sel == SEL_NONE;
            prdata <= '0;
            if (apb_access && !pwrite) begin
                case (sel)
                    // Reads show the executing instruction's address.
                    SEL_PCL: prdata <= {24'h000000, exec.addr[7:0]};
                    SEL_STATUS: begin
                        // Stack level and pointer are deliberately absent.
                        prdata[`ST_FULL_BIT] <= stack_full;
                        prdata[`ST_OVF_BIT] <= overflow_reg;
                        prdata[`ST_HELD_BIT] <= irq_req && stack_full;
                        prdata[`ST_PAGE_LSB+2:`ST_PAGE_LSB] <= exec.addr[`PC_WIDTH-1:8];
                    end
                    SEL_CONTROL: prdata[`CTL_RUN_BIT] <= run_reg;
                    default: prdata <= '0;
                endcase
            end
        end
    end

    // Pending low-byte write; a new write in the clearing cycle stays pending.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pcl_pending_reg <= 1'b0;
            pcl_data_reg <= '0;
        end else if (apb_write && sel == SEL_PCL) begin
            pcl_pending_reg <= 1'b1;
            pcl_data_reg <= pwdata[7:0];
        end else if (boundary && do_pcl) begin
            pcl_pending_reg <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_reg <= `CTL_RUN_RST;
        end else if (apb_write && sel == SEL_CONTROL) begin
            run_reg <= pwdata[`CTL_RUN_BIT];
        end
    end

    // Sticky overflow, cleared by writing one; a new overflow wins over the clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow_reg <= 1'b0;
        end else if (push && stack_full) begin
            overflow_reg <= 1'b1;
        end else if (apb_write && sel == SEL_STATUS && pwdata[`ST_OVF_BIT]) begin
            overflow_reg <= 1'b0;
        end
    end

endmodule : pc_fetch_pipeline_stack

// ---- hdl/seq_params.svh ----
// Constants for the instruction sequencer: offsets, fields, resets and counts.
`ifndef SEQ_PARAMS_SVH
`define SEQ_PARAMS_SVH

`define PC_WIDTH 11
`define WORD_WIDTH 16
`define PADDR_WIDTH 12
`define PHASE_COUNT 4
`define STACK_DEPTH 8
`define RESET_VECTOR 11'h000

`define OFS_PC_LOW 12'h000
`define OFS_STATUS 12'h004
`define OFS_CONTROL 12'h008

`define ST_FULL_BIT 0
`define ST_OVF_BIT 1
`define ST_HELD_BIT 2
`define ST_PAGE_LSB 4
`define CTL_RUN_BIT 0
`define CTL_RUN_RST 1'b1

`endif

// ---- hdl/seq_pkg.sv ----
// Types shared by the instruction sequencer and its decoder partner.
`include "seq_params.svh"

package seq_pkg;

    typedef enum logic [2:0] {
        OP_SEQ = 3'b000,
        OP_JUMP = 3'b001,
        OP_CALL = 3'b010,
        OP_RET = 3'b011,
        OP_RETURN_FROM_IRQ_OP = 3'b100,
        OP_SKIP = 3'b101
    } op_kind_t;

    typedef enum logic [1:0] {
        SEL_NONE = 2'b00,
        SEL_PCL = 2'b01,
        SEL_STATUS = 2'b10,
        SEL_CONTROL = 2'b11
    } reg_sel_t;

    typedef struct packed {
        op_kind_t op;
        logic skip_taken;
        logic [`PC_WIDTH-1:0] target;
    } decode_t;

    typedef struct packed {
        logic valid;
        logic [`PC_WIDTH-1:0] addr;
        logic [`WORD_WIDTH-1:0] word;
    } exec_t;

endpackage : seq_pkg

// ---- hdl/phase_gen.sv ----
// Four-phase ring that splits the clock into instruction-cycle phases.
`timescale 1ns/1ps
`include "seq_params.svh"

module phase_gen #(
    parameter int PHASES = `PHASE_COUNT
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // One-hot phase, bit 0 is the fetch phase
    output logic [PHASES-1:0] phase
);

    // A rotating one-hot ring can never show two phases at once.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= {{(PHASES-1){1'b0}}, 1'b1};
        end else begin
            phase <= {phase[PHASES-2:0], phase[PHASES-1]};
        end
    end

endmodule : phase_gen

// ---- hdl/return_stack.sv ----
// Hidden circular return-address stack.
`timescale 1ns/1ps
`include "seq_params.svh"

module return_stack #(
    parameter int DEPTH = `STACK_DEPTH,
    parameter int WIDTH = `PC_WIDTH
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Push and pop requests, never both at once
    input wire logic push,
    input wire logic pop,
    input wire logic [WIDTH-1:0] push_data,
    // Top entry and fill state
    output logic [WIDTH-1:0] top_data,
    output logic full
);

    localparam int PTR_W = $clog2(DEPTH);
    localparam logic [PTR_W:0] LEVEL_MAX = (PTR_W+1)'(DEPTH);

    logic [WIDTH-1:0] entry [DEPTH];
    logic [PTR_W-1:0] ptr_reg;
    logic [PTR_W-1:0] wr_idx;
    logic [PTR_W:0] level_reg;
    logic [PTR_W:0] level_next;

    assign wr_idx = ptr_reg + 1'b1;
    assign top_data = entry[ptr_reg];

    generate
        for (genvar i = 0; i < DEPTH; i++) begin : g_entry
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    entry[i] <= '0;
                end else if (push && wr_idx == PTR_W'(i)) begin
                    // On a full stack this slot holds the oldest entry.
                    entry[i] <= push_data;
                end
            end
        end
    endgenerate

    always_comb begin
        level_next = level_reg;
        if (push && level_reg != LEVEL_MAX) begin
            level_next = level_reg + 1'b1;
        end else if (pop && level_reg != '0) begin
            level_next = level_reg - 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr_reg <= PTR_W'(DEPTH - 1);
            level_reg <= '0;
            full <= 1'b0;
        end else begin
            if (push) begin
                ptr_reg <= wr_idx;
            end else if (pop && level_reg != '0) begin
                ptr_reg <= ptr_reg - 1'b1;
            end
            level_reg <= level_next;
            full <= (level_next == LEVEL_MAX);
        end
    end

endmodule : return_stack

// ---- verif/seq_partner.sv ----
// Program memory, decoder and interrupt source facing the sequencer.
`timescale 1ns/1ps
`include "seq_params.svh"
module seq_partner (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Memory and decoder
    input wire logic [`PC_WIDTH-1:0] fetch_addr,
    output logic [`WORD_WIDTH-1:0] fetch_word,
    input wire seq_pkg::exec_t exec,
    output seq_pkg::decode_t decode,
    // Interrupt source
    input wire logic raise,
    input wire logic irq_ack,
    output logic irq_req
);
    import seq_pkg::*;
    // Word layout: kind in 15:13, skip outcome in 12, target in 10:0.
    logic [`WORD_WIDTH-1:0] mem [0:2047];
    assign fetch_word = mem[fetch_addr];
    assign decode = {exec.word[15:13], exec.word[12], exec.word[10:0]};
    // The flag is kept until acknowledged, so a held request is never lost.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            irq_req <= 1'b0;
        else if (irq_ack)
            irq_req <= 1'b0;
        else if (raise)
            irq_req <= 1'b1;
    end
endmodule : seq_partner

// ---- verif/seq_asserts.sv ----
// Port checker for the instruction sequencer.
`timescale 1ns/1ps
`include "seq_params.svh"
module seq_asserts (
    // Clock, reset and bus
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    // Core side
    input wire logic [`PC_WIDTH-1:0] fetch_addr,
    input wire seq_pkg::exec_t exec,
    input wire seq_pkg::decode_t decode,
    input wire logic [`PC_WIDTH-1:0] irq_vector,
    input wire logic irq_ack,
    input wire logic stack_full,
    input wire logic [`PHASE_COUNT-1:0] phase
);
    import seq_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_load;
        phase[3] && exec.valid && decode.op inside {OP_JUMP, OP_CALL};
    endsequence
    sequence s_redirect;
        phase[3] && exec.valid && (decode.op inside {OP_JUMP, OP_CALL, OP_RET, OP_RETURN_FROM_IRQ_OP}
            || decode.op == OP_SKIP && decode.skip_taken);
    endsequence
    a_phase_ring: assert property (
        1 |=> phase == {$past(phase[2:0]), $past(phase[3])}) else $error("phase ring");
    a_fetch_hold: assert property (
        !phase[3] |=> $stable(fetch_addr)) else $error("fetch moved mid cycle");
    a_exec_hold: assert property (
        !phase[3] |=> $stable(exec)) else $error("exec moved mid cycle");
    a_exec_pairs: assert property (
        phase[3] ##1 exec.valid |-> exec.addr == $past(fetch_addr)) else $error("exec pairing");
    a_branch_dummy: assert property (
        s_redirect |=> !exec.valid) else $error("no dummy cycle");
    a_load_target: assert property (
        s_load |=> fetch_addr == $past(decode.target)) else $error("target not loaded");
    a_ack_held: assert property (
        phase[3] && stack_full |=> !irq_ack) else $error("ack on full stack");
    a_ack_vector: assert property (
        irq_ack |-> $past(phase[3]) && fetch_addr == irq_vector) else $error("ack vector");
    a_apb_wait: assert property (
        psel && penable && !pready |=> pready) else $error("bus answer late");
endmodule : seq_asserts
bind pc_fetch_pipeline_stack seq_asserts u_chk (.pclk, .presetn, .psel, .penable, .pready,
    .fetch_addr, .exec, .decode, .irq_vector, .irq_ack, .stack_full, .phase);

// ---- verif/pc_fetch_pipeline_stack_tb_top.sv ----
// Self-checking bench for the sequencer against a reference model.
`timescale 1ns/1ps
`include "seq_params.svh"
module pc_fetch_pipeline_stack_tb_top;
    import seq_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, raise = 0;
    logic [`PADDR_WIDTH-1:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic pready, pslverr, irq_req, irq_ack, stack_full;
    logic [`PC_WIDTH-1:0] fetch_addr;
    logic [`WORD_WIDTH-1:0] fetch_word;
    exec_t exec;
    decode_t decode;
    logic [`PHASE_COUNT-1:0] phase;
    localparam logic [`PC_WIDTH-1:0] VEC = 11'h300;
    int bad_count = 0, n_compared = 0;
    int m_pc = 0, m_ea = 0, m_ev = 0, m_ack = 0, cnt = 0, wp = 0, pend = -1;
    int wr_pcl = 0, wr_dat = 0;
    int stk [8];
    always #5 pclk = ~pclk;
    pc_fetch_pipeline_stack DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .fetch_addr, .fetch_word, .exec, .decode, .irq_req,
        .irq_vector(VEC), .irq_ack, .stack_full, .phase);
    seq_partner PM (.pclk, .presetn, .fetch_addr, .fetch_word, .exec, .decode, .raise,
        .irq_ack, .irq_req);
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    task automatic report_and_stop;
        if (bad_count == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : report_and_stop
    task automatic push(input int v);
        stk[wp] = v;
        wp = (wp + 1) % 8;
        if (cnt < 8)
            cnt++;
    endtask : push
    // Reference step at a cycle boundary; a push on a full stack drops the oldest.
    task automatic step;
        int op, w, nx, br;
        m_ack = 0;
        w = PM.mem[m_ea];
        op = m_ev ? w[15:13] : 0;
        nx = m_pc + 1;
        br = 1;
        if (op == OP_CALL)
            push(m_pc);
        if (op == OP_CALL || op == OP_JUMP)
            nx = w[10:0];
        if (op == OP_RET || op == OP_RETURN_FROM_IRQ_OP) begin
            wp = (wp + 7) % 8;
            cnt--;
            nx = stk[wp];
        end
        if (op == OP_SEQ || op == OP_SKIP && !w[12]) begin
            if (pend >= 0) begin
                nx = (m_pc & 'h700) | pend;
                pend = -1;
            end else if (irq_req && cnt < 8) begin
                push(m_pc);
                nx = VEC;
                m_ack = 1;
            end else
                br = 0;
        end
        m_ev = !br;
        m_ea = m_pc;
        m_pc = nx & 'h7FF;
    endtask : step
    always @(posedge pclk) begin
        // A low-byte write taken on a boundary edge only counts from the following boundary.
        wr_pcl = psel && penable && !pready && pwrite && paddr == `OFS_PC_LOW;
        wr_dat = pwdata[7:0];
        if (presetn && phase === 4'h8) begin
            step();
            #1;
            check("fetch_addr", m_pc, fetch_addr);
            check("exec.valid", m_ev, exec.valid);
            if (m_ev)
                check("exec.word", PM.mem[m_ea], exec.word);
            check("irq_ack", m_ack, irq_ack);
            check("stack_full", cnt == 8, stack_full);
        end
        if (wr_pcl)
            pend = wr_dat;
    end
    task automatic apb(input logic w, input int a, input int d, output logic [31:0] q,
            output logic e);
        int i;
        // One edge always passes, so a release and the next request never share a step.
        @(posedge pclk);
        for (i = 0; i < 8 && phase !== 4'h8; i++)
            @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        for (i = 0; i < 20 && pready !== 1'b1; i++)
            @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        if (i == 20) begin
            check("pready", 1, 0);
            report_and_stop();
        end
    endtask : apb
    task automatic wait_for(input int a);
        int i;
        for (i = 0; i < 600 && fetch_addr !== a; i++)
            @(posedge pclk);
        if (i == 600) begin
            bad_count++;
            report_and_stop();
        end
    endtask : wait_for
    function automatic logic [15:0] enc(input op_kind_t op, input int t);
        return {op, t[12:0]};
    endfunction : enc
    initial begin
        int i;
        logic [31:0] q;
        logic e;
        for (i = 0; i < 2048; i++)
            PM.mem[i] = 16'h0000;
        PM.mem[1] = enc(OP_SKIP, 'h1000);
        PM.mem[2] = enc(OP_JUMP, 'h050);
        PM.mem[3] = enc(OP_JUMP, 'h100);
        for (i = 0; i < 9; i++) begin
            PM.mem['h100 + 2 * i] = enc(OP_CALL, 'h102 + 2 * i);
            PM.mem['h101 + 2 * i] = enc(OP_RET, 0);
        end
        PM.mem['h103] = enc(OP_JUMP, 'h200);
        PM.mem['h112] = enc(OP_RET, 0);
        PM.mem['h301] = enc(OP_RETURN_FROM_IRQ_OP, 0);
        void'($urandom(35));
        repeat (8) @(posedge pclk);
        presetn <= 1;
        wait_for('h110);
        raise <= 1;
        @(posedge pclk);
        raise <= 0;
        wait_for('h201);
        for (i = 0; i < 4; i++)
            apb(1, `OFS_PC_LOW, $urandom & 'h7F, q, e);
        apb(0, `OFS_PC_LOW, 0, q, e);
        check("pcl read", m_ea & 'hFF, q);
        apb(0, `OFS_STATUS, 0, q, e);
        check("status", ((m_ea >> 8) << 4) | 2, q);
        apb(1, `OFS_STATUS, 2, q, e);
        apb(0, `OFS_STATUS, 0, q, e);
        check("status clr", (m_ea >> 8) << 4, q);
        apb(0, `OFS_CONTROL, 0, q, e);
        check("control", 1, q);
        apb(0, 'h00C, 0, q, e);
        check("pslverr", 1, e);
        check("unmapped", 0, q);
        report_and_stop();
    end
endmodule : pc_fetch_pipeline_stack_tb_top
